// ===== hw/tim_consts.svh
// constants of the timer interrupt mask block: offsets, field positions, resets
// assumes a 32-bit apb register map, one aligned word per register
`ifndef TIM_CONSTS_SVH
`define TIM_CONSTS_SVH

`define TIM_ADDR_W          12
`define TIM_OFF_MASK        12'h018
`define TIM_OFF_RAW         12'h01C
`define TIM_OFF_MIS         12'h020
`define TIM_OFF_CLR         12'h024

`define TIM_BIT_TA_TO       0
`define TIM_BIT_CA_MATCH    1
`define TIM_BIT_CA_EVENT    2
`define TIM_BIT_RTC         3
`define TIM_BIT_TB_TO       8
`define TIM_BIT_CB_MATCH    9

// writable enable bits: 9:8 and 3:0, reserved 7:4 and 31:10 read zero
`define TIM_IMPL_MASK       32'h0000_030F
`define TIM_RESET_VAL       32'h0000_0000
`define TIM_NUM_EVT         6

`endif

// ===== hw/tim_pkg.sv
// types of the timer interrupt mask block
// assumes tim_consts.svh defines the event count
`include "tim_consts.svh"

package tim_pkg;

    // one pulse per timer event source
    typedef struct packed {
        logic cb_match;
        logic tb_timeout;
        logic rtc_match;
        logic ca_event;
        logic ca_match;
        logic ta_timeout;
    } tim_evt_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tim_apb_req_t;

endpackage : tim_pkg

// ===== hw/tim_int_mask.sv
// timer interrupt enable mask, raw/masked status and clear, on an apb slave
// assumes event pulses come from logic on pclk; one pclk domain throughout
`timescale 1ns/100ps
`include "tim_consts.svh"

// Overview of operation
// [R1] bit 9 of the mask register enables the capture b match interrupt, reset 0.
// [R2] bit 3 of the mask register enables the rtc match interrupt, reset 0.
// [R3] bit 2 of the mask register enables the capture a event interrupt, reset 0.
// [R4] bit 1 of the mask register enables the capture a match interrupt, reset 0.
// [R5] bit 0 of the mask register enables the timer a time-out interrupt, reset 0.
// [R6] bits 7 to 4 of the mask register are reserved, read zero and ignore writes.
// [R7] bit 8 of the mask register enables the timer b time-out interrupt, reset 0.
// [R8] a raw status bit sets on its event whatever the mask holds.
// [R9] a masked status bit is the and of raw status and its enable.
// [R10] writing one to a clear register bit clears that raw status bit; zero does nothing.
module tim_int_mask
    import tim_pkg::*;
(
    // apb slave
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire tim_apb_req_t           apb_req,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // timer events, one-cycle pulses
    input  wire tim_evt_t               evt,
    // controller-level interrupt
    output logic                        irq
);

    logic [31:0] mask_reg;
    logic [31:0] raw_reg;
    logic [31:0] evt_word;
    logic        wr_en;
    logic        rd_en;
    logic        setup;
    logic        clr_wr;
    logic [31:0] clr_bits;
    logic [31:0] rdata_next;
    logic        err_next;

    function automatic logic [31:0] evt_to_word(input tim_evt_t e);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`TIM_BIT_TA_TO]    = e.ta_timeout;
        w[`TIM_BIT_CA_MATCH] = e.ca_match;
        w[`TIM_BIT_CA_EVENT] = e.ca_event;
        w[`TIM_BIT_RTC]      = e.rtc_match;
        w[`TIM_BIT_TB_TO]    = e.tb_timeout;
        w[`TIM_BIT_CB_MATCH] = e.cb_match;
        return w;
    endfunction : evt_to_word

    function automatic logic addr_known(input logic [11:0] a);
        return (a == `TIM_OFF_MASK) || (a == `TIM_OFF_RAW) ||
               (a == `TIM_OFF_MIS)  || (a == `TIM_OFF_CLR);
    endfunction : addr_known

    assign evt_word = evt_to_word(evt);
    // answer with no wait state: pready rises in the first access cycle
    assign setup    = apb_req.psel && !apb_req.penable;
    assign wr_en    = apb_req.psel && apb_req.penable && pready && apb_req.pwrite;
    assign rd_en    = apb_req.psel && apb_req.penable && pready && !apb_req.pwrite;
    assign clr_wr   = wr_en && (apb_req.paddr == `TIM_OFF_CLR);
    assign clr_bits = clr_wr ? (apb_req.pwdata & `TIM_IMPL_MASK) : 32'h0000_0000;

    // pready registered: high for exactly the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= setup;
    end

    // [R1] mask bit writes
    // [R2] [R3] [R4] [R5] [R7] only implemented enables store
    // [R6] reserved bits never store
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_reg <= `TIM_RESET_VAL;
        else if (wr_en && apb_req.paddr == `TIM_OFF_MASK)
            mask_reg <= apb_req.pwdata & `TIM_IMPL_MASK;
    end

    // [R8] raw set ignores mask
    // [R10] clear by one, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            raw_reg <= `TIM_RESET_VAL;
        else
            raw_reg <= (raw_reg & ~clr_bits) | evt_word;
    end

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        err_next   = 1'b0;
        if (setup && !apb_req.pwrite)
        begin
            unique case (apb_req.paddr)
                `TIM_OFF_MASK: rdata_next = mask_reg;
                `TIM_OFF_RAW:  rdata_next = raw_reg;
                // [R9] masked status read
                `TIM_OFF_MIS:  rdata_next = raw_reg & mask_reg;
                default:       rdata_next = 32'h0000_0000;
            endcase
        end
        // unmapped address answers with an error, write ignored
        if (setup && !addr_known(apb_req.paddr))
            err_next = 1'b1;
    end

    // read data captured at setup, held through the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata  <= rdata_next;
            pslverr <= err_next;
        end
        else if (pready)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // [R9] interrupt from masked status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(((raw_reg & ~clr_bits) | evt_word) & mask_reg);
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_raw_sets_unmasked: assert property ( // [R8]
        evt.rtc_match |=> raw_reg[`TIM_BIT_RTC])
        else $error("raw rtc bit not set by event");

    chk_clear_one_bit: assert property ( // [R10]
        clr_wr && apb_req.pwdata[`TIM_BIT_TA_TO] && !evt.ta_timeout
        |=> !raw_reg[`TIM_BIT_TA_TO])
        else $error("raw timer a bit survived clear");

    chk_clear_zero_keeps: assert property ( // [R10]
        clr_wr && !apb_req.pwdata[`TIM_BIT_CB_MATCH] && raw_reg[`TIM_BIT_CB_MATCH]
        |=> raw_reg[`TIM_BIT_CB_MATCH])
        else $error("writing zero cleared a raw bit");

    chk_reserved_zero: assert property ( // [R6]
        mask_reg[7:4] == 4'h0 && mask_reg[31:10] == 22'h0)
        else $error("reserved mask bits not zero");

    chk_mask_write_cb: assert property ( // [R1]
        wr_en && apb_req.paddr == `TIM_OFF_MASK
        |=> mask_reg[`TIM_BIT_CB_MATCH] == $past(apb_req.pwdata[`TIM_BIT_CB_MATCH]))
        else $error("capture b match enable not written");

    chk_mask_write_low: assert property ( // [R5]
        wr_en && apb_req.paddr == `TIM_OFF_MASK
        |=> mask_reg[3:0] == $past(apb_req.pwdata[3:0]))
        else $error("low enables not written");

    chk_mask_write_tb: assert property ( // [R7]
        wr_en && apb_req.paddr == `TIM_OFF_MASK
        |=> mask_reg[`TIM_BIT_TB_TO] == $past(apb_req.pwdata[`TIM_BIT_TB_TO]))
        else $error("timer b enable not written");

    chk_irq_follows_mis: assert property ( // [R9]
        irq == |$past((raw_reg & ~clr_bits | evt_word) & mask_reg))
        else $error("irq disagrees with masked status");

    chk_masked_off_quiet: assert property ( // [R9]
        mask_reg == 32'h0 && $past(mask_reg) == 32'h0 ##1 mask_reg == 32'h0 |-> !irq)
        else $error("irq raised while all masked");

    chk_ready_one_cycle: assert property (
        pready |=> !pready)
        else $error("pready held beyond one cycle");

    // each event source reaches its own raw bit
    chk_raw_sets_ta: assert property ( // [R8]
        evt.ta_timeout |=> raw_reg[`TIM_BIT_TA_TO])
        else $error("raw timer a bit not set by event");

    chk_raw_sets_cam: assert property ( // [R8]
        evt.ca_match |=> raw_reg[`TIM_BIT_CA_MATCH])
        else $error("raw capture a match bit not set by event");

    chk_raw_sets_cae: assert property ( // [R8]
        evt.ca_event |=> raw_reg[`TIM_BIT_CA_EVENT])
        else $error("raw capture a event bit not set by event");

    chk_raw_sets_tb: assert property ( // [R8]
        evt.tb_timeout |=> raw_reg[`TIM_BIT_TB_TO])
        else $error("raw timer b bit not set by event");

    chk_raw_sets_cb: assert property ( // [R8]
        evt.cb_match |=> raw_reg[`TIM_BIT_CB_MATCH])
        else $error("raw capture b match bit not set by event");

    // the raw rtc bit never rises without its event
    chk_raw_no_spurious: assert property ( // [R8]
        !evt.rtc_match && !raw_reg[`TIM_BIT_RTC] |=> !raw_reg[`TIM_BIT_RTC])
        else $error("raw rtc bit set without event");

    chk_raw_read_only: assert property ( // [R8]
        wr_en && apb_req.paddr == `TIM_OFF_RAW && evt_word == 32'h0
        |=> $stable(raw_reg))
        else $error("write to raw status changed it");

    chk_raw_reserved: assert property ( // [R6]
        raw_reg[7:4] == 4'h0 && raw_reg[31:10] == 22'h0)
        else $error("reserved raw bits not zero");

    // per-bit enable writes
    chk_mask_write_rtc: assert property ( // [R2]
        wr_en && apb_req.paddr == `TIM_OFF_MASK
        |=> mask_reg[`TIM_BIT_RTC] == $past(apb_req.pwdata[`TIM_BIT_RTC]))
        else $error("rtc enable not written");

    chk_mask_write_cae: assert property ( // [R3]
        wr_en && apb_req.paddr == `TIM_OFF_MASK
        |=> mask_reg[`TIM_BIT_CA_EVENT] == $past(apb_req.pwdata[`TIM_BIT_CA_EVENT]))
        else $error("capture a event enable not written");

    chk_mask_write_cam: assert property ( // [R4]
        wr_en && apb_req.paddr == `TIM_OFF_MASK
        |=> mask_reg[`TIM_BIT_CA_MATCH] == $past(apb_req.pwdata[`TIM_BIT_CA_MATCH]))
        else $error("capture a match enable not written");

    // enables move only on a completed mask write
    chk_mask_hold: assert property ( // [R1]
        !(wr_en && apb_req.paddr == `TIM_OFF_MASK) |=> $stable(mask_reg))
        else $error("mask changed without a mask write");

    // clear by one, set wins on a collision
    chk_clear_cb: assert property ( // [R10]
        clr_wr && apb_req.pwdata[`TIM_BIT_CB_MATCH] && !evt.cb_match
        |=> !raw_reg[`TIM_BIT_CB_MATCH])
        else $error("raw capture b bit survived clear");

    chk_clear_set_wins: assert property ( // [R10]
        clr_wr && evt.ca_match |=> raw_reg[`TIM_BIT_CA_MATCH])
        else $error("clear beat a same-cycle event");

    // irq against masked status, independent of the next-state term
    chk_irq_quiet: assert property ( // [R9]
        (raw_reg & mask_reg) == 32'h0 && (evt_word & mask_reg) == 32'h0 |=> !irq)
        else $error("irq raised with nothing unmasked");

    chk_irq_raised: assert property ( // [R9]
        (raw_reg & mask_reg) != 32'h0 && !clr_wr |=> irq)
        else $error("irq missing with an unmasked bit set");

    // bus answer timing
    chk_ready_after_setup: assert property (
        setup |=> pready)
        else $error("no pready after setup");

    chk_idle_outputs_zero: assert property (
        !pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside the access cycle");

    chk_err_unmapped: assert property (
        setup && !addr_known(apb_req.paddr) |=> pslverr)
        else $error("unmapped address not refused");

    cov_masked_irq: cover property (evt.ca_event && mask_reg[`TIM_BIT_CA_EVENT] ##1 irq);
    cov_set_and_clear: cover property (evt.ca_match && clr_wr);
    cov_bad_addr: cover property (pslverr && pready);
    cov_mis_read: cover property (rd_en && apb_req.paddr == `TIM_OFF_MIS && prdata != 0);

endmodule : tim_int_mask

// ===== test/tim_int_mask_bench.sv
// self-checking bench for the timer interrupt mask block over apb
// assumes tim_pkg and tim_consts.svh are compiled first
`timescale 1ns/100ps
`include "tim_consts.svh"

module tim_int_mask_bench
    import tim_pkg::*;
;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    tim_apb_req_t apb_req = '0;
    tim_evt_t     evt = '0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         irq;
    logic [31:0]  q;
    logic         err;
    int           error_cnt = 0;
    int           num_checks = 0;
    int           pos [6] = '{0, 1, 2, 3, 8, 9};

    always #5 pclk = ~pclk;

    tim_int_mask i_dut
    (
        .pclk    (pclk),
        .presetn (presetn),
        .apb_req (apb_req),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .evt     (evt),
        .irq     (irq)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // entered just after a rising edge; ends one idle edge after the access
    // outputs read at the falling edge, where they stand settled up to the
    // rising edge that completes the access
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            error_cnt++;
            conclude();
        end
        q = prdata;
        err = pslverr;
        @(posedge pclk);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        check(q, exp);
        check({31'h0, err}, 32'h0000_0000);
    endtask : rdchk

    task automatic irqchk(input logic e);
        #1;
        check({31'h0, irq}, {31'h0, e});
        @(posedge pclk);
    endtask : irqchk

    // pulse lasts one cycle, then one idle edge; the registered irq rises at the same edge as the raw bit
    task automatic pulse(input tim_evt_t e);
        evt <= e;
        @(posedge pclk);
        evt <= '0;
        @(posedge pclk);
    endtask : pulse

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(`TIM_OFF_MASK, 32'h0000_0000);
        rdchk(`TIM_OFF_RAW, 32'h0000_0000);
        for (int i = 0; i < 6; i++)
        begin
            xfer(1'b1, `TIM_OFF_MASK, 32'h0000_0000);
            pulse(tim_evt_t'(6'(1) << i));
            irqchk(1'b0);
            rdchk(`TIM_OFF_RAW, 32'h1 << pos[i]);
            rdchk(`TIM_OFF_MIS, 32'h0000_0000);
            xfer(1'b1, `TIM_OFF_MASK, 32'h1 << pos[i]);
            irqchk(1'b1);
            rdchk(`TIM_OFF_MIS, 32'h1 << pos[i]);
            rdchk(`TIM_OFF_MASK, 32'h1 << pos[i]);
            xfer(1'b1, `TIM_OFF_CLR, ~(32'h1 << pos[i]));
            rdchk(`TIM_OFF_RAW, 32'h1 << pos[i]);
            xfer(1'b1, `TIM_OFF_CLR, 32'h1 << pos[i]);
            irqchk(1'b0);
            rdchk(`TIM_OFF_RAW, 32'h0000_0000);
        end
        xfer(1'b1, `TIM_OFF_MASK, 32'hFFFF_FFFF);
        rdchk(`TIM_OFF_MASK, 32'h0000_030F);
        xfer(1'b1, 12'h040, 32'hFFFF_FFFF);
        check({31'h0, err}, 32'h0000_0001);
        rdchk(`TIM_OFF_MASK, 32'h0000_030F);
        conclude();
    end
endmodule : tim_int_mask_bench
